//--- hdl/srt_capture.v
// Functional notes
// - Timestamp mode marks sample, clocks untouched.
// - Normal mode resyncs divider, DDC, monitor, link.
// - Synchronization mode bit resets to zero.
// - Selector value five routes timestamp to bit.
// - Delay register shifts the marked sample.
// - Every channel has identical pipeline latency.
// - No timestamp while decimation is active.
// - Nonzero mode field arms the capture machine.
// - N-shot mode field clears after capture.
// - Transition bit picks rising or falling reference.
// - Edge bit picks rising or falling clock.
// - N-shot discards programmed events before acting.
// - Monitor byte holds hold and setup status.
// - Low statuses flag possible setup error.
// - Midscale setup with hold up to midscale, or midscale hold with setup above midscale or zero, reports no error.
// - High hold with zero setup flags hold.
`timescale 1ns/1ps
`include "srt_consts.vh"

module srt_capture #(
  parameter NCH  = 4,
  parameter SW   = 14,
  parameter PIPE = 4
) (
  input  wire                  mclk,
  input  wire                  rstn,
  input  wire [`SRT_AW-1:0]    reg_addr,
  input  wire [`SRT_DW-1:0]    reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [`SRT_DW-1:0]    reg_rdata,
  input  wire                  ref_in,
  input  wire [3:0]            setup_raw,
  input  wire [3:0]            hold_raw,
  input  wire [NCH*SW-1:0]     sample_in,
  output wire [NCH*SW-1:0]     sample_out,
  output wire [2:0]            ctrl_bits,
  output reg                   div_en,
  output reg  [3:0]            resync_q,
  output wire                  mon_setup_err,
  output wire                  mon_hold_err,
  output wire                  mon_ok
);

  // Register storage
  reg  [`SRT_DW-1:0]     clk_div_q;
  reg  [`SRT_DW-1:0]     ref_ctrl_q;
  reg  [`SRT_DW-1:0]     ref_skip_q;
  reg  [`SRT_DW-1:0]     ts_delay_q;
  reg  [`SRT_DW-1:0]     sync_mode_q;
  reg  [`SRT_DW-1:0]     app_mode_q;
  reg  [`SRT_DW-1:0]     cb_lo_q;
  reg  [`SRT_DW-1:0]     cb_hi_q;
  reg  [`SRT_DW-1:0]     cb_cnt_q;
  reg  [3:0]             setup_q;
  reg  [3:0]             hold_q;

  // Capture path
  reg                    ref_rise_q;
  reg                    ref_fall_q;
  reg                    ref_fall_rt_q;
  reg                    ref_s_q;
  reg                    ref_p_q;
  reg                    ref_prim_q;
  wire                   ref_now;
  wire                   ref_evt;

  // Arming machine
  reg  [1:0]             st_q;
  reg  [1:0]             st_d;
  reg  [4:0]             skip_cnt_q;
  reg  [4:0]             skip_cnt_d;
  wire [1:0]             mode_f;
  wire                   mode_wr;
  wire                   accept;

  // Marking and divider
  reg  [`SRT_DW-1:0]     dly_cnt_q;
  reg                    dly_busy_q;
  wire                   mark_in;
  reg  [PIPE-1:0]        mark_pipe_q;
  reg  [SW*NCH-1:0]      pipe_q [0:PIPE-1];
  reg  [2:0]             ctrl_q;
  reg  [3:0]             div_cnt_q;
  wire [3:0]             div_top;
  wire                   ts_mode;
  wire                   ts_allow;
  wire [1:0]             cb_count;
  integer                i;

  // Divide code 0..3 gives ratio 1,2,4,8 minus one
  function [3:0] div_last;
    input [2:0] code;
    begin
      case (code)
        3'h1:    div_last = 4'h1;
        3'h2:    div_last = 4'h3;
        3'h3:    div_last = 4'h7;
        default: div_last = 4'h0;
      endcase
    end
  endfunction

  // Control bit k carries the mark when enabled and routed
  function cb_mark;
    input [1:0] count;
    input [1:0] idx;
    input [2:0] func;
    input       mark;
    begin
      cb_mark = (idx < count) && (func == `SRT_FUNC_TS) && mark;
    end
  endfunction

  // Window decode: 0 = ok, 1 = setup, 2 = hold, 3 = setup or hold
  function [1:0] win_decode;
    input [3:0] hold;
    input [3:0] setup;
    begin
      if (hold == 4'h0 && setup == 4'h0)
      begin
        win_decode = 2'h3;
      end
      else if (hold == 4'h0 && setup < `SRT_MON_MID)
      begin
        win_decode = 2'h1;
      end
      else if (setup == `SRT_MON_MID && hold <= `SRT_MON_MID)
      begin
        win_decode = 2'h0;
      end
      else if (hold == `SRT_MON_MID && (setup > `SRT_MON_MID || setup == 4'h0))
      begin
        win_decode = 2'h0;
      end
      else if (hold > `SRT_MON_MID && setup == 4'h0)
      begin
        win_decode = 2'h2;
      end
      else
      begin
        win_decode = 2'h3;
      end
    end
  endfunction

  assign mode_f   = ref_ctrl_q[`SRT_MODE_MSB:`SRT_MODE_LSB];
  assign cb_count = cb_cnt_q[`SRT_CNT_MSB:`SRT_CNT_LSB];
  assign div_top  = div_last(clk_div_q[`SRT_DIV_MSB:`SRT_DIV_LSB]);
  assign ts_mode  = sync_mode_q[`SRT_SYNC_BIT];
  assign ts_allow = ts_mode && !app_mode_q[`SRT_DECIM_BIT];
  assign mode_wr  = reg_wr && (reg_addr == `SRT_A_REF_CTRL);

  // Falling-edge capture gives half a cycle more setup; retimed once
  always @(negedge mclk or negedge rstn)
  begin
    if (!rstn)
      ref_fall_q <= 1'b0;
    else
      ref_fall_q <= ref_in;
  end

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_rise_q    <= 1'b0;
      ref_fall_rt_q <= 1'b0;
      ref_s_q       <= 1'b0;
      ref_p_q       <= 1'b0;
      ref_prim_q    <= 1'b0;
    end
    else
    begin
      ref_rise_q    <= ref_in;
      ref_fall_rt_q <= ref_fall_q;
      ref_s_q       <= ref_now;
      ref_p_q       <= ref_s_q;
      ref_prim_q    <= 1'b1;
    end
  end

  // Edge choice equalises latency so both paths mark the same sample
  assign ref_now = ref_ctrl_q[`SRT_EDGE_BIT] ? ref_fall_rt_q : ref_rise_q;

  // Transition choice; first cycle after reset never counts
  assign ref_evt = ref_prim_q &&
                   (ref_ctrl_q[`SRT_TRAN_BIT] ? (ref_p_q && !ref_s_q)
                                               : (!ref_p_q && ref_s_q));

  assign accept = (st_q == `SRT_ST_RUN) && ref_evt;

  always @*
  begin
    st_d       = st_q;
    skip_cnt_d = skip_cnt_q;
    case (st_q)
      `SRT_ST_IDLE:
      begin
        if (mode_f == `SRT_MODE_NSHOT && skip_cnt_q != 5'h00)
          st_d = `SRT_ST_SKIP;
        else if (mode_f != `SRT_MODE_OFF)
          st_d = `SRT_ST_RUN;
      end
      `SRT_ST_SKIP:
      begin
        if (mode_f == `SRT_MODE_OFF)
          st_d = `SRT_ST_IDLE;
        else if (ref_evt)
        begin
          skip_cnt_d = skip_cnt_q - 5'h01;
          if (skip_cnt_q == 5'h01)
            st_d = `SRT_ST_RUN;
        end
      end
      `SRT_ST_RUN:
      begin
        if (mode_f == `SRT_MODE_OFF || (accept && mode_f == `SRT_MODE_NSHOT))
          st_d = `SRT_ST_IDLE;
      end
      default:
        st_d = `SRT_ST_IDLE;
    endcase
    if (mode_wr)
      skip_cnt_d = ref_skip_q[`SRT_SKIP_MSB:0];
  end

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q       <= `SRT_ST_IDLE;
      skip_cnt_q <= 5'h00;
    end
    else
    begin
      st_q       <= mode_wr ? `SRT_ST_IDLE : st_d;
      skip_cnt_q <= skip_cnt_d;
    end
  end

  // Register writes; a software write in the clearing cycle wins
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_div_q   <= `SRT_RST_BYTE;
      ref_ctrl_q  <= `SRT_RST_BYTE;
      ref_skip_q  <= `SRT_RST_BYTE;
      ts_delay_q  <= `SRT_RST_BYTE;
      sync_mode_q <= `SRT_RST_BYTE;
      app_mode_q  <= `SRT_RST_BYTE;
      cb_lo_q     <= `SRT_RST_BYTE;
      cb_hi_q     <= `SRT_RST_BYTE;
      cb_cnt_q    <= `SRT_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SRT_A_CLK_DIV)
        clk_div_q <= reg_wdata;
      else if (reg_addr == `SRT_A_REF_CTRL)
        ref_ctrl_q <= {reg_wdata[7:1], 1'b0};
      else if (reg_addr == `SRT_A_REF_SKIP)
        ref_skip_q <= reg_wdata;
      else if (reg_addr == `SRT_A_TS_DELAY)
        ts_delay_q <= reg_wdata;
      else if (reg_addr == `SRT_A_SYNC_MODE)
        sync_mode_q <= reg_wdata;
      else if (reg_addr == `SRT_A_APP_MODE)
        app_mode_q <= reg_wdata;
      else if (reg_addr == `SRT_A_CB_FUNC_LO)
        cb_lo_q <= reg_wdata;
      else if (reg_addr == `SRT_A_CB_FUNC_HI)
        cb_hi_q <= reg_wdata;
      else if (reg_addr == `SRT_A_CB_COUNT)
        cb_cnt_q <= reg_wdata;
    end
    else if (accept && mode_f == `SRT_MODE_NSHOT)
      ref_ctrl_q[`SRT_MODE_MSB:`SRT_MODE_LSB] <= `SRT_MODE_OFF;
  end

  // Read port, data valid in the cycle after the strobe
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= `SRT_RD_ZERO;
    else if (!reg_rd)
      reg_rdata <= `SRT_RD_ZERO;
    else if (reg_addr == `SRT_A_CLK_DIV)
      reg_rdata <= clk_div_q;
    else if (reg_addr == `SRT_A_REF_CTRL)
      reg_rdata <= ref_ctrl_q;
    else if (reg_addr == `SRT_A_REF_SKIP)
      reg_rdata <= ref_skip_q;
    else if (reg_addr == `SRT_A_TS_DELAY)
      reg_rdata <= ts_delay_q;
    else if (reg_addr == `SRT_A_SH_MON)
      reg_rdata <= {hold_q, setup_q};
    else if (reg_addr == `SRT_A_SYNC_MODE)
      reg_rdata <= sync_mode_q;
    else if (reg_addr == `SRT_A_APP_MODE)
      reg_rdata <= app_mode_q;
    else if (reg_addr == `SRT_A_CB_FUNC_LO)
      reg_rdata <= cb_lo_q;
    else if (reg_addr == `SRT_A_CB_FUNC_HI)
      reg_rdata <= cb_hi_q;
    else if (reg_addr == `SRT_A_CB_COUNT)
      reg_rdata <= cb_cnt_q;
    else
      reg_rdata <= `SRT_RD_ZERO;
  end

  // Window detector status latched at every reference transition of the selected direction, armed or not
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_q <= 4'h0;
      hold_q  <= 4'h0;
    end
    else if (ref_evt)
    begin
      setup_q <= setup_raw;
      hold_q  <= hold_raw;
    end
  end

  assign mon_ok        = (win_decode(hold_q, setup_q) == 2'h0);
  assign mon_setup_err = win_decode(hold_q, setup_q) == 2'h1 ||
                         win_decode(hold_q, setup_q) == 2'h3;
  assign mon_hold_err  = win_decode(hold_q, setup_q) == 2'h2 ||
                         win_decode(hold_q, setup_q) == 2'h3;

  // Normal mode: one-cycle realign pulse to divider, DDC, monitor, link
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      resync_q <= 4'h0;
    else
      resync_q <= {4{accept && !ts_mode}};
  end

  // Clock divider realigned by the reference, left alone in timestamp mode
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt_q <= 4'h0;
      div_en    <= 1'b0;
    end
    else if (accept && !ts_mode)
    begin
      div_cnt_q <= 4'h0;
      div_en    <= 1'b0;
    end
    else
    begin
      div_en    <= (div_cnt_q == 4'h0);
      div_cnt_q <= (div_cnt_q >= div_top) ? 4'h0 : div_cnt_q + 4'h1;
    end
  end

  // Delay countdown; a new event while busy is dropped, never doubled
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dly_cnt_q  <= 8'h00;
      dly_busy_q <= 1'b0;
    end
    else if (dly_busy_q)
    begin
      dly_cnt_q  <= dly_cnt_q - 8'h01;
      dly_busy_q <= (dly_cnt_q != 8'h01);
    end
    else if (accept && ts_allow && ts_delay_q != 8'h00)
    begin
      dly_cnt_q  <= ts_delay_q;
      dly_busy_q <= 1'b1;
    end
  end

  assign mark_in = (dly_busy_q && dly_cnt_q == 8'h01) ||
                   (!dly_busy_q && accept && ts_allow && ts_delay_q == 8'h00);

  // Shared pipeline; the mark meets the sample taken beside the reference
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      mark_pipe_q <= {PIPE{1'b0}};
      ctrl_q      <= 3'h0;
      for (i = 0; i < PIPE; i = i + 1)
        pipe_q[i] <= {SW*NCH{1'b0}};
    end
    else
    begin
      pipe_q[0] <= sample_in;
      for (i = 1; i < PIPE; i = i + 1)
        pipe_q[i] <= pipe_q[i-1];
      mark_pipe_q <= {mark_pipe_q[PIPE-2:0], 1'b0};
      mark_pipe_q[`SRT_MARK_STAGE] <= mark_in;
      ctrl_q[0] <= cb_mark(cb_count, 2'h0, cb_lo_q[`SRT_CB0_MSB:`SRT_CB0_LSB],
                           mark_pipe_q[PIPE-1]);
      ctrl_q[1] <= cb_mark(cb_count, 2'h1, cb_lo_q[`SRT_CB1_MSB:`SRT_CB1_LSB],
                           mark_pipe_q[PIPE-1]);
      ctrl_q[2] <= cb_mark(cb_count, 2'h2, cb_hi_q[`SRT_CB2_MSB:`SRT_CB2_LSB],
                           mark_pipe_q[PIPE-1]);
    end
  end

  // Output stage registered beside the control bits
  reg  [SW*NCH-1:0]      out_q;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      out_q <= {SW*NCH{1'b0}};
    else
      out_q <= pipe_q[PIPE-1];
  end

  assign sample_out = out_q;
  assign ctrl_bits  = ctrl_q;

endmodule // srt_capture

//--- hdl/srt_consts.vh
`ifndef SRT_CONSTS_VH
`define SRT_CONSTS_VH

`define SRT_AW              12
`define SRT_DW              8

`define SRT_A_CLK_DIV       12'h10b
`define SRT_A_REF_CTRL      12'h120
`define SRT_A_REF_SKIP      12'h121
`define SRT_A_TS_DELAY      12'h123
`define SRT_A_SH_MON        12'h128
`define SRT_A_SYNC_MODE     12'h1ff
`define SRT_A_APP_MODE      12'h200
`define SRT_A_CB_FUNC_LO    12'h559
`define SRT_A_CB_FUNC_HI    12'h55a
`define SRT_A_CB_COUNT      12'h58f

`define SRT_RST_BYTE        8'h00

`define SRT_DIV_LSB         0
`define SRT_DIV_MSB         2
`define SRT_MODE_LSB        1
`define SRT_MODE_MSB        2
`define SRT_EDGE_BIT        3
`define SRT_TRAN_BIT        4
`define SRT_SKIP_MSB        4
`define SRT_SYNC_BIT        0
`define SRT_DECIM_BIT       0
`define SRT_CB0_LSB         0
`define SRT_CB0_MSB         2
`define SRT_CB1_LSB         4
`define SRT_CB1_MSB         6
`define SRT_CB2_LSB         0
`define SRT_CB2_MSB         2
`define SRT_CNT_LSB         6
`define SRT_CNT_MSB         7
`define SRT_MARK_STAGE      2

`define SRT_MODE_OFF        2'h0
`define SRT_MODE_CONT       2'h1
`define SRT_MODE_NSHOT      2'h2
`define SRT_FUNC_TS         3'h5

`define SRT_ST_IDLE         2'h0
`define SRT_ST_SKIP         2'h1
`define SRT_ST_RUN          2'h2

`define SRT_MON_MID         4'h8
`define SRT_RD_ZERO         8'h00

`endif

//--- tb/srt_capture_properties.sv
`timescale 1ns/1ps
`include "srt_consts.vh"
module srt_capture_chk #(
  parameter NCH  = 4,
  parameter SW   = 14,
  parameter PIPE = 4
) (
  input wire                 mclk,
  input wire                 rstn,
  input wire [`SRT_AW-1:0]   reg_addr,
  input wire [`SRT_DW-1:0]   reg_wdata,
  input wire                 reg_wr,
  input wire                 reg_rd,
  input wire [`SRT_DW-1:0]   reg_rdata,
  input wire                 ref_in,
  input wire [NCH*SW-1:0]    sample_in,
  input wire [NCH*SW-1:0]    sample_out,
  input wire [2:0]           ctrl_bits,
  input wire [3:0]           resync_q
);
  logic       ref_q;
  logic [3:0] since_q;
  logic [3:0] up_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Saturating counters, so long idle spans stay cheap
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_q   <= 1'b0;
      since_q <= 4'hf;
      up_q    <= 4'h0;
    end
    else
    begin
      ref_q   <= ref_in;
      since_q <= (ref_in != ref_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
      up_q    <= up_q + {3'h0, up_q != 4'hf};
    end
  end

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

  property p_resync_all;
    |resync_q |-> &resync_q;
  endproperty
  a_resync_all: assert property (p_resync_all) else $error("partial resync");

  property p_resync_once;
    |resync_q |=> resync_q == 4'h0;
  endproperty
  a_resync_once: assert property (p_resync_once) else $error("resync too long");

  property p_resync_cause;
    resync_q[0] |-> since_q <= 4'h6;
  endproperty
  a_resync_cause: assert property (p_resync_cause) else $error("resync without edge");

  property p_ctrl_once;
    |ctrl_bits |=> ctrl_bits == 3'h0;
  endproperty
  a_ctrl_once: assert property (p_ctrl_once) else $error("mark too long");

  property p_mode_excl;
    |resync_q |-> (ctrl_bits == 3'h0) [*8];
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("mark in normal mode");

  property p_ts_readback;
    reg_wr && reg_addr == `SRT_A_TS_DELAY ##1 !reg_wr ##1 reg_rd && reg_addr == `SRT_A_TS_DELAY
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_ts_readback: assert property (p_ts_readback) else $error("delay readback");

  property p_lat;
    up_q > PIPE + 1 |-> sample_out == $past(sample_in, PIPE + 1);
  endproperty
  a_lat: assert property (p_lat) else $error("sample latency");
endmodule // srt_capture_chk

bind srt_capture srt_capture_chk #(.NCH(NCH), .SW(SW), .PIPE(PIPE)) i_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
  .sample_in(sample_in), .sample_out(sample_out), .ctrl_bits(ctrl_bits),
  .resync_q(resync_q));

//--- tb/srt_ref_gen.sv
`timescale 1ns/1ps
module srt_ref_gen #(
  parameter MIN_HI = 2
) (
  input  wire  mclk,
  output logic ref_in
);
  initial ref_in = 1'b0;

  // Never shorter than the minimum width, so short requests are stretched
  task automatic hold(input logic lvl, input int cyc);
    @(posedge mclk);
    ref_in <= lvl;
    repeat (((cyc < MIN_HI) ? MIN_HI : cyc) - 1) @(posedge mclk);
  endtask

  // Equal halves keep a steady period in continuous use
  task automatic pulse(input int w);
    hold(1'b1, w);
    hold(1'b0, w);
  endtask
endmodule // srt_ref_gen

//--- tb/tb_srt_capture.sv
`timescale 1ns/1ps
`include "srt_consts.vh"
module tb_srt_capture;
  localparam NCH   = 4;
  localparam SW    = 14;
  localparam PIPE  = 4;
  localparam LIMIT = 5000;
  logic              mclk, rstn, reg_wr, reg_rd, ref_in, div_en, ref_p, rs_pp, rs_en;
  logic              mon_setup_err, mon_hold_err, mon_ok;
  logic [11:0]       reg_addr;
  logic [7:0]        reg_wdata, reg_rdata;
  logic [3:0]        setup_raw, hold_raw, resync_q;
  logic [2:0]        ctrl_bits, ts_bits;
  logic [NCH*SW-1:0] sample_in, sample_out;
  logic [SW-1:0]     ts_val, ref_r, exp_v;
  int                mismatches, cmp_count, cyc, rs_cnt, ts_cnt, b_rs, b_ts, en_cnt, b_en;
  // Hold, setup, ok, setup error, hold error, error flags checked
  logic [11:0]       rows [7] = '{12'h035, 12'h489, 12'h089, 12'h899, 12'h809,
                                  12'hf03, 12'h007};
  logic [7:0]        trs [4] = '{8'h02, 8'h0a, 8'h12, 8'h1a};

  srt_capture #(.NCH(NCH), .SW(SW), .PIPE(PIPE)) i_srt_capture (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
    .setup_raw(setup_raw), .hold_raw(hold_raw), .sample_in(sample_in),
    .sample_out(sample_out), .ctrl_bits(ctrl_bits), .div_en(div_en),
    .resync_q(resync_q), .mon_setup_err(mon_setup_err),
    .mon_hold_err(mon_hold_err), .mon_ok(mon_ok));
  srt_ref_gen i_srt_ref_gen (.mclk(mclk), .ref_in(ref_in));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Samples carry the cycle number, so a mark names its own cycle
  always @(posedge mclk)
  begin
    cyc       <= cyc + 1;
    sample_in <= {NCH{SW'(cyc + 1)}};
    ref_p     <= ref_in;
    if (ref_in && !ref_p)
      ref_r <= SW'(cyc);
    if (resync_q != 4'h0)
      rs_cnt <= rs_cnt + 1;
    rs_pp     <= (resync_q != 4'h0);
    if (rs_pp)
      rs_en <= div_en;
    if (div_en)
      en_cnt <= en_cnt + 1;
    if (ctrl_bits != 3'h0)
    begin
      ts_cnt  <= ts_cnt + 1;
      ts_bits <= ctrl_bits;
      ts_val  <= sample_out[SW-1:0];
    end
    if (cyc == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
    @(posedge mclk);
  endtask

  task ev();
    i_srt_ref_gen.pulse(4);
    repeat (12) @(posedge mclk);
  endtask

  task print_verdict();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    setup_raw = 4'h0;
    hold_raw = 4'h0;
    sample_in = '0;
    ref_p = 1'b0;
    rs_pp = 1'b0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    wr(`SRT_A_REF_CTRL, 8'h02);
    for (int i = 0; i < 7; i++)
    begin
      hold_raw  <= rows[i][11:8];
      setup_raw <= rows[i][7:4];
      b_rs = rs_cnt;
      ev();
      rd(`SRT_A_SH_MON, rows[i][11:4]);
      chk(16'(mon_ok), 16'(rows[i][3]));
      if (rows[i][0])
        chk(16'({mon_setup_err, mon_hold_err}), 16'(rows[i][2:1]));
      chk(16'(rs_cnt - b_rs), 16'h1);
    end
    // Divide by 8: four enables in 32 cycles, then a 16-cycle reference pulse realigns them
    wr(`SRT_A_CLK_DIV, 8'h03);
    repeat (16) @(posedge mclk);
    b_en = en_cnt;
    repeat (32) @(posedge mclk);
    chk(16'(en_cnt - b_en), 16'h4);
    i_srt_ref_gen.hold(1'b1, 16);
    i_srt_ref_gen.hold(1'b0, 16);
    chk(16'(rs_en), 16'h1);
    wr(`SRT_A_CLK_DIV, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(`SRT_A_REF_CTRL, trs[i]);
      b_rs = rs_cnt;
      i_srt_ref_gen.hold(1'b1, 10);
      chk(16'(rs_cnt - b_rs), 16'(!trs[i][4]));
      i_srt_ref_gen.hold(1'b0, 10);
      chk(16'(rs_cnt - b_rs), 16'h1);
    end
    wr(`SRT_A_REF_SKIP, 8'h02);
    wr(`SRT_A_REF_CTRL, 8'h04);
    b_rs = rs_cnt;
    for (int i = 0; i < 4; i++)
    begin
      ev();
      chk(16'(rs_cnt - b_rs), 16'(i >= 2));
    end
    rd(`SRT_A_REF_CTRL, 8'h00);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(`SRT_A_SYNC_MODE, 8'h00);
    rd(12'h7fe, 8'h00);
    wr(`SRT_A_SH_MON, 8'hff);
    rd(`SRT_A_SH_MON, 8'h00);
    wr(`SRT_A_SYNC_MODE, 8'h01);
    wr(`SRT_A_CB_COUNT, 8'hc0);
    wr(`SRT_A_REF_CTRL, 8'h02);
    for (int k = 0; k < 3; k++)
    begin
      wr(`SRT_A_CB_FUNC_LO, (k == 0) ? 8'h05 : ((k == 1) ? 8'h50 : 8'h00));
      wr(`SRT_A_CB_FUNC_HI, (k == 2) ? 8'h05 : 8'h00);
      wr(`SRT_A_TS_DELAY, 8'(k));
      rd(`SRT_A_TS_DELAY, 8'(k));
      b_rs = rs_cnt;
      b_ts = ts_cnt;
      ev();
      exp_v = ref_r + SW'(k);
      chk(16'(ts_cnt - b_ts), 16'h1);
      chk(16'(ts_bits), 16'(3'h1 << k));
      chk(16'(ts_val), 16'(exp_v));
      chk(16'(rs_cnt - b_rs), 16'h0);
    end
    wr(`SRT_A_APP_MODE, 8'h01);
    b_ts = ts_cnt;
    ev();
    chk(16'(ts_cnt - b_ts), 16'h0);
    wr(`SRT_A_APP_MODE, 8'h00);
    wr(`SRT_A_REF_CTRL, 8'h00);
    ev();
    chk(16'(ts_cnt - b_ts), 16'h0);
    print_verdict();
  end
endmodule // tb_srt_capture
